/* File: common/uifc_pkg.sv */
package uifc_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [31:0] ADDR_DIV_LOW        = 32'h5000_1100;
  localparam logic [31:0] ADDR_IEN_DIV_HIGH   = 32'h5000_1104;
  localparam logic [31:0] ADDR_IDENT_FIFO_CTL = 32'h5000_1108;
  localparam logic [31:0] ADDR_LINE_CTRL      = 32'h5000_110c;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ********************************************************
  // Field layouts
  // ********************************************************
  localparam int unsigned IEN_PROG_TXE    = 7;
  localparam int unsigned IEN_MODEM       = 3;
  localparam int unsigned IEN_LINE        = 2;
  localparam int unsigned IEN_TXE         = 1;
  localparam int unsigned IEN_RXD         = 0;
  localparam logic [7:0]  IEN_WRITE_MASK  = 8'h8f;
  localparam int unsigned FC_FIFO_EN      = 0;
  localparam int unsigned FC_RX_FLUSH     = 1;
  localparam int unsigned FC_TX_FLUSH     = 2;
  localparam int unsigned FC_XFER_MODE    = 3;
  localparam int unsigned FC_TX_THR_LSB   = 4;
  localparam int unsigned FC_RX_TRIG_LSB  = 6;
  localparam int unsigned LINE_DIV_SEL    = 7;
  localparam int unsigned IDENT_CODE_LSB  = 0;
  localparam int unsigned IDENT_STATE_LSB = 6;
  localparam logic [1:0]  FIFO_STATE_ON   = 2'h3;
  localparam logic [1:0]  FIFO_STATE_OFF  = 2'h0;

  // ********************************************************
  // FIFO levels, depth 16
  // ********************************************************
  localparam logic [4:0]  CNT_ZERO         = 5'h00;
  localparam logic [4:0]  RX_LVL_ONE       = 5'h01;
  localparam logic [4:0]  RX_LVL_QUARTER   = 5'h04;
  localparam logic [4:0]  RX_LVL_HALF      = 5'h08;
  localparam logic [4:0]  RX_LVL_NEAR_FULL = 5'h0e;
  localparam logic [4:0]  TX_LVL_EMPTY     = 5'h00;
  localparam logic [4:0]  TX_LVL_TWO       = 5'h02;
  localparam logic [4:0]  TX_LVL_QUARTER   = 5'h04;
  localparam logic [4:0]  TX_LVL_HALF      = 5'h08;

  // ********************************************************
  // Baud generator
  // ********************************************************
  localparam logic [15:0] DIV_ZERO   = 16'h0000;
  localparam logic [15:0] DIV_ONE    = 16'h0001;
  localparam logic [3:0]  PHASE_LAST = 4'hf;
  localparam logic [3:0]  PHASE_STEP = 4'h1;

  typedef enum logic [3:0] {
    ID_MODEM    = 4'h0,
    ID_NONE     = 4'h1,
    ID_TX_EMPTY = 4'h2,
    ID_RX_DATA  = 4'h4,
    ID_LINE     = 4'h6,
    ID_BUSY     = 4'h7,
    ID_TIMEOUT  = 4'hc
  } uifc_ident_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } uifc_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } uifc_axil_rsp_t;

  typedef struct packed {
    logic lineStatus;
    logic charTimeout;
    logic txHoldingEmpty;
    logic modemStatus;
    logic busyDetect;
  } uifc_irq_src_t;

  typedef struct packed {
    logic        awReady;
    logic        wReady;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [7:0]  irqEnable;
    logic [7:0]  divLow;
    logic [7:0]  divHigh;
    logic        divLatchSel;
    logic        fifoEnable;
    logic        xferMode;
    logic [1:0]  rxTrig;
    logic [1:0]  txThresh;
    logic        rxFlush;
    logic        txFlush;
    logic        irqOut;
    logic        rtsN;
    logic        dmaRxReqN;
    logic        dmaTxReqN;
    logic [15:0] divCount;
    logic [3:0]  phase16;
    logic        sampleTick;
    logic        bitTick;
  } uifc_state_t;

  localparam uifc_state_t STATE_RESET = '{
    awReady: 1'b1, wReady: 1'b1, arReady: 1'b1, rtsN: 1'b1,
    dmaRxReqN: 1'b1, dmaTxReqN: 1'b1, default: '0};

endpackage

/* File: design/uifc_irq_ident.sv */
`timescale 1ns/10ps
module uifc_irq_ident (
  input  wire logic             lineIrq,    // Line status pending
  input  wire logic             timeoutIrq, // Character timeout pending
  input  wire logic             rxDataIrq,  // Receive data pending
  input  wire logic             txEmptyIrq, // Transmit empty pending
  input  wire logic             modemIrq,   // Modem status pending
  input  wire logic             busyIrq,    // Busy detect pending
  output uifc_pkg::uifc_ident_t identCode   // Highest pending source
);

  // ********************************************************
  // Fixed priority encoder
  // ********************************************************
  always_comb begin
    identCode = uifc_pkg::ID_NONE;
    if (lineIrq) begin
      identCode = uifc_pkg::ID_LINE;
    end else if (timeoutIrq) begin
      identCode = uifc_pkg::ID_TIMEOUT;
    end else if (rxDataIrq) begin
      identCode = uifc_pkg::ID_RX_DATA;
    end else if (txEmptyIrq) begin
      identCode = uifc_pkg::ID_TX_EMPTY;
    end else if (modemIrq) begin
      identCode = uifc_pkg::ID_MODEM;
    end else if (busyIrq) begin
      identCode = uifc_pkg::ID_BUSY;
    end
  end

endmodule

/* File: design/uifc_top.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module uifc_top (
  input  wire logic                     clk,          // Clock
  input  wire logic                     rst,          // Async reset
  input  wire uifc_pkg::uifc_axil_req_t axilReq,      // Bus request
  output uifc_pkg::uifc_axil_rsp_t      axilRsp,      // Bus response
  input  wire uifc_pkg::uifc_irq_src_t  irqSrc,       // Raw sources
  input  wire logic [4:0]               rxFifoCount,  // Receive fill
  input  wire logic [4:0]               txFifoCount,  // Transmit fill
  input  wire logic                     autoFlowEnable, // Autoflow on
  input  wire logic                     rtsRequest,   // Software RTS
  output logic                          irq,          // Interrupt
  output logic                          rtsN,         // Request to send
  output logic                          dmaRxReqN,    // Receive request
  output logic                          dmaTxReqN,    // Transmit request
  output logic                          fifoEnable,   // FIFO mode
  output logic                          rxFifoFlush,  // Receive flush
  output logic                          txFifoFlush,  // Transmit flush
  output logic                          divLatchSel,  // Divisor select
  output logic [15:0]                   baudDivisor,  // Divisor value
  output logic                          sampleTick,   // 16x tick
  output logic                          bitTick       // Bit tick
);

  uifc_pkg::uifc_state_t st_reg;
  uifc_pkg::uifc_state_t st_next;
  uifc_pkg::uifc_ident_t identCode;
  logic [4:0]            rxLevel;
  logic [4:0]            txLevel;
  logic                  rxAtTrig;
  logic                  txAtThresh;
  logic                  progTxEmptyIrqMode;
  logic                  lineIrq;
  logic                  rxDataIrq;
  logic                  timeoutIrq;
  logic                  txEmptyIrq;
  logic                  modemIrq;
  logic                  anyPending;
  logic                  writeFire;
  logic [15:0]           divisorValue;

  // ********************************************************
  // Trigger level decode
  // ********************************************************
  function automatic logic [4:0] rxLevelOf(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = uifc_pkg::RX_LVL_ONE;
    case (sel)
      2'h0: lvl = uifc_pkg::RX_LVL_ONE;
      2'h1: lvl = uifc_pkg::RX_LVL_QUARTER;
      2'h2: lvl = uifc_pkg::RX_LVL_HALF;
      default: lvl = uifc_pkg::RX_LVL_NEAR_FULL;
    endcase
    return lvl;
  endfunction

  function automatic logic [4:0] txLevelOf(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = uifc_pkg::TX_LVL_EMPTY;
    case (sel)
      2'h0: lvl = uifc_pkg::TX_LVL_EMPTY;
      2'h1: lvl = uifc_pkg::TX_LVL_TWO;
      2'h2: lvl = uifc_pkg::TX_LVL_QUARTER;
      default: lvl = uifc_pkg::TX_LVL_HALF;
    endcase
    return lvl;
  endfunction

  assign rxLevel    = rxLevelOf(st_reg.rxTrig);
  assign txLevel    = txLevelOf(st_reg.txThresh);
  assign rxAtTrig   = rxFifoCount >= rxLevel;
  assign txAtThresh = txFifoCount <= txLevel;
  assign divisorValue = {st_reg.divHigh, st_reg.divLow};

  // ********************************************************
  // Interrupt source gating
  // ********************************************************
  assign progTxEmptyIrqMode =
    st_reg.irqEnable[uifc_pkg::IEN_PROG_TXE] & st_reg.fifoEnable;
  assign lineIrq = st_reg.irqEnable[uifc_pkg::IEN_LINE]
                   & irqSrc.lineStatus;
  assign rxDataIrq = st_reg.irqEnable[uifc_pkg::IEN_RXD]
                     & (st_reg.fifoEnable ? rxAtTrig
                        : (rxFifoCount != uifc_pkg::CNT_ZERO));
  assign timeoutIrq = st_reg.irqEnable[uifc_pkg::IEN_RXD]
                      & st_reg.fifoEnable
                      & irqSrc.charTimeout;
  assign txEmptyIrq = st_reg.irqEnable[uifc_pkg::IEN_TXE]
                      & (progTxEmptyIrqMode ? txAtThresh
                         : irqSrc.txHoldingEmpty);
  assign modemIrq = st_reg.irqEnable[uifc_pkg::IEN_MODEM]
                    & irqSrc.modemStatus;

  uifc_irq_ident u_ident (
    .lineIrq    (lineIrq),
    .timeoutIrq (timeoutIrq),
    .rxDataIrq  (rxDataIrq),
    .txEmptyIrq (txEmptyIrq),
    .modemIrq   (modemIrq),
    .busyIrq    (irqSrc.busyDetect),
    .identCode  (identCode)
  );

  assign anyPending = identCode != uifc_pkg::ID_NONE;
  assign writeFire  = !st_reg.awReady && !st_reg.wReady
                      && !st_reg.bValid;

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [7:0]  wb;
    rd = '0;
    rr = uifc_pkg::RESP_OKAY;
    wb = st_reg.wData[7:0];
    st_next = st_reg;
    st_next.rxFlush    = 1'b0;
    st_next.txFlush    = 1'b0;
    st_next.sampleTick = 1'b0;
    st_next.bitTick    = 1'b0;

    // Write address and data, taken in either order
    if (axilReq.awvalid && st_reg.awReady) begin
      st_next.awReady = 1'b0;
      st_next.awAddr  = axilReq.awaddr;
    end
    if (axilReq.wvalid && st_reg.wReady) begin
      st_next.wReady = 1'b0;
      st_next.wData  = axilReq.wdata;
      st_next.wStrb  = axilReq.wstrb;
    end
    if (writeFire) begin
      st_next.bValid = 1'b1;
      st_next.bResp  = uifc_pkg::RESP_OKAY;
      if (st_reg.awAddr == uifc_pkg::ADDR_DIV_LOW) begin
        if (st_reg.wStrb[0] && st_reg.divLatchSel) begin
          st_next.divLow = wb;
        end
      end else if (st_reg.awAddr == uifc_pkg::ADDR_IEN_DIV_HIGH) begin
        if (st_reg.wStrb[0] && st_reg.divLatchSel) begin
          st_next.divHigh = wb;
        end else if (st_reg.wStrb[0]) begin
          st_next.irqEnable = wb & uifc_pkg::IEN_WRITE_MASK;
        end
      end else if (st_reg.awAddr == uifc_pkg::ADDR_IDENT_FIFO_CTL) begin
        if (st_reg.wStrb[0]) begin
          st_next.fifoEnable = wb[uifc_pkg::FC_FIFO_EN];
          st_next.rxFlush  = wb[uifc_pkg::FC_RX_FLUSH];
          st_next.txFlush  = wb[uifc_pkg::FC_TX_FLUSH];
          st_next.xferMode = wb[uifc_pkg::FC_XFER_MODE];
          st_next.txThresh = wb[uifc_pkg::FC_TX_THR_LSB +: 2];
          st_next.rxTrig   = wb[uifc_pkg::FC_RX_TRIG_LSB +: 2];
        end
      end else if (st_reg.awAddr == uifc_pkg::ADDR_LINE_CTRL) begin
        if (st_reg.wStrb[0]) begin
          st_next.divLatchSel = wb[uifc_pkg::LINE_DIV_SEL];
        end
      end else begin
        st_next.bResp = uifc_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.bValid && axilReq.bready) begin
      st_next.bValid  = 1'b0;
      st_next.awReady = 1'b1;
      st_next.wReady  = 1'b1;
    end

    // Read decode
    if (axilReq.araddr == uifc_pkg::ADDR_DIV_LOW) begin
      if (st_reg.divLatchSel) begin
        rd[7:0] = st_reg.divLow;
      end
    end else if (axilReq.araddr == uifc_pkg::ADDR_IEN_DIV_HIGH) begin
      rd[7:0] = st_reg.divLatchSel ? st_reg.divHigh
                                   : st_reg.irqEnable;
    end else if (axilReq.araddr == uifc_pkg::ADDR_IDENT_FIFO_CTL) begin
      rd[uifc_pkg::IDENT_CODE_LSB +: 4] = identCode;
      rd[uifc_pkg::IDENT_STATE_LSB +: 2] =
        st_reg.fifoEnable ? uifc_pkg::FIFO_STATE_ON
                          : uifc_pkg::FIFO_STATE_OFF;
    end else if (axilReq.araddr == uifc_pkg::ADDR_LINE_CTRL) begin
      rd[uifc_pkg::LINE_DIV_SEL] = st_reg.divLatchSel;
    end else begin
      rr = uifc_pkg::RESP_SLVERR;
    end
    if (axilReq.arvalid && st_reg.arReady) begin
      st_next.arReady = 1'b0;
      st_next.rValid  = 1'b1;
      st_next.rData   = rd;
      st_next.rResp   = rr;
    end
    if (st_reg.rValid && axilReq.rready) begin
      st_next.rValid  = 1'b0;
      st_next.arReady = 1'b1;
    end

    // Interrupt, flow control and transfer requests
    st_next.irqOut = anyPending;
    st_next.rtsN = !(rtsRequest && !(autoFlowEnable
                   && st_reg.fifoEnable && rxAtTrig));
    if (!st_reg.fifoEnable) begin
      st_next.dmaRxReqN = !(rxFifoCount != uifc_pkg::CNT_ZERO);
      st_next.dmaTxReqN = !irqSrc.txHoldingEmpty;
    end else if (st_reg.xferMode) begin
      st_next.dmaRxReqN = !(rxAtTrig || irqSrc.charTimeout);
      st_next.dmaTxReqN = !txAtThresh;
    end else begin
      st_next.dmaRxReqN = !(rxFifoCount != uifc_pkg::CNT_ZERO);
      st_next.dmaTxReqN = !(txFifoCount == uifc_pkg::CNT_ZERO);
    end

    // Baud generator, clock over sixteen times divisor
    if (divisorValue == uifc_pkg::DIV_ZERO) begin
      st_next.divCount = uifc_pkg::DIV_ZERO;
      st_next.phase16  = '0;
    end else if (st_reg.divCount >= divisorValue - uifc_pkg::DIV_ONE) begin
      st_next.divCount   = uifc_pkg::DIV_ZERO;
      st_next.sampleTick = 1'b1;
      st_next.phase16    = st_reg.phase16 + uifc_pkg::PHASE_STEP;
      st_next.bitTick    = st_reg.phase16 == uifc_pkg::PHASE_LAST;
    end else begin
      st_next.divCount = st_reg.divCount + uifc_pkg::DIV_ONE;
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= uifc_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign axilRsp.awready = st_reg.awReady;
  assign axilRsp.wready  = st_reg.wReady;
  assign axilRsp.bvalid  = st_reg.bValid;
  assign axilRsp.bresp   = st_reg.bResp;
  assign axilRsp.arready = st_reg.arReady;
  assign axilRsp.rvalid  = st_reg.rValid;
  assign axilRsp.rdata   = st_reg.rData;
  assign axilRsp.rresp   = st_reg.rResp;
  assign irq         = st_reg.irqOut;
  assign rtsN        = st_reg.rtsN;
  assign dmaRxReqN   = st_reg.dmaRxReqN;
  assign dmaTxReqN   = st_reg.dmaTxReqN;
  assign fifoEnable  = st_reg.fifoEnable;
  assign rxFifoFlush = st_reg.rxFlush;
  assign txFifoFlush = st_reg.txFlush;
  assign divLatchSel = st_reg.divLatchSel;
  assign baudDivisor = divisorValue;
  assign sampleTick  = st_reg.sampleTick;
  assign bitTick     = st_reg.bitTick;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence sDivHighWrite;
    writeFire && st_reg.wStrb[0] && st_reg.divLatchSel
    && st_reg.awAddr == uifc_pkg::ADDR_IEN_DIV_HIGH;
  endsequence

  AST_DIV_HIGH_ALIAS:
  assert property (sDivHighWrite |=> st_reg.divHigh
                   == $past(st_reg.wData[7:0])
                   && $stable(st_reg.irqEnable))
    else $error("Divisor high byte write misrouted");

  AST_PROG_TXE_GATE:
  assert property (progTxEmptyIrqMode && !txAtThresh
                   |-> identCode != uifc_pkg::ID_TX_EMPTY)
    else $error("Transmit empty reported above threshold");

  AST_MODEM_GATE:
  assert property (!st_reg.irqEnable[uifc_pkg::IEN_MODEM]
                   |-> identCode != uifc_pkg::ID_MODEM)
    else $error("Modem status reported while disabled");

  AST_LINE_TOP:
  assert property (st_reg.irqEnable[uifc_pkg::IEN_LINE]
                   && irqSrc.lineStatus
                   |-> identCode == uifc_pkg::ID_LINE)
    else $error("Line status not highest priority");

  AST_RXD_GATE:
  assert property (!st_reg.irqEnable[uifc_pkg::IEN_RXD]
                   |-> identCode != uifc_pkg::ID_RX_DATA
                   && identCode != uifc_pkg::ID_TIMEOUT)
    else $error("Receive source reported while disabled");

  sequence sIdentRead;
    axilReq.arvalid && st_reg.arReady
    && axilReq.araddr == uifc_pkg::ADDR_IDENT_FIFO_CTL;
  endsequence

  AST_IDENT_READ:
  assert property (sIdentRead |=> st_reg.rValid
                   && st_reg.rData[3:0] == $past(identCode)
                   && st_reg.rData[7:6] == ($past(st_reg.fifoEnable)
                      ? uifc_pkg::FIFO_STATE_ON
                      : uifc_pkg::FIFO_STATE_OFF))
    else $error("Identification readback wrong");

  sequence sTxFlushWrite;
    writeFire && st_reg.wStrb[0]
    && st_reg.awAddr == uifc_pkg::ADDR_IDENT_FIFO_CTL
    && st_reg.wData[uifc_pkg::FC_TX_FLUSH];
  endsequence

  AST_TX_FLUSH_PULSE:
  assert property (sTxFlushWrite |=> st_reg.txFlush
                   ##1 !st_reg.txFlush)
    else $error("Transmit flush not a single pulse");

  AST_IRQ_FOLLOWS:
  assert property (##1 st_reg.irqOut == $past(anyPending))
    else $error("Interrupt output does not follow pending");

  AST_RTS_HOLD_OFF:
  assert property (autoFlowEnable && st_reg.fifoEnable && rxAtTrig
                   |=> st_reg.rtsN)
    else $error("Request to send held at trigger");

  AST_DMA_RX_MODE1:
  assert property (st_reg.fifoEnable && st_reg.xferMode && rxAtTrig
                   |=> !st_reg.dmaRxReqN)
    else $error("Receive transfer request missing");

  AST_DIV_ONE_TICK:
  assert property (divisorValue == uifc_pkg::DIV_ONE
                   |=> st_reg.sampleTick)
    else $error("Divisor one gives no tick each cycle");

endmodule

/* File: verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam logic [31:0] AD = uifc_pkg::ADDR_DIV_LOW;
  localparam logic [31:0] AI = uifc_pkg::ADDR_IEN_DIV_HIGH;
  localparam logic [31:0] AF = uifc_pkg::ADDR_IDENT_FIFO_CTL;
  localparam logic [31:0] AL = uifc_pkg::ADDR_LINE_CTRL;
  localparam logic [4:0]  RXL [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  localparam logic [4:0]  TXL [4] = '{5'h00, 5'h02, 5'h04, 5'h08};
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  uifc_pkg::uifc_axil_req_t req = '0;
  uifc_pkg::uifc_axil_rsp_t rsp;
  uifc_pkg::uifc_irq_src_t  src = '0;
  logic [4:0]  rxCnt, txCnt, rxLd = '0, txLd = '0, trg = 5'h01, thr = '0;
  logic        load = 1'b0, af = 1'b0, rtsReq = 1'b0, fe = 1'b0, xm = 1'b0;
  logic        irq, rtsN, dmaRxN, dmaTxN, rxFl, txFl, bitTick, feOut, dls;
  logic        smp;
  logic [7:0]  ien = '0, e, x;
  logic [15:0] div;
  logic [31:0] seed = 32'hb016;
  int          numErrors = 0, checks = 0, n, m;

  always #50 clk = ~clk;

  uifc_top i_dut (.clk(clk), .rst(rst), .axilReq(req), .axilRsp(rsp),
    .irqSrc(src), .rxFifoCount(rxCnt), .txFifoCount(txCnt),
    .autoFlowEnable(af), .rtsRequest(rtsReq), .irq(irq), .rtsN(rtsN),
    .dmaRxReqN(dmaRxN), .dmaTxReqN(dmaTxN), .fifoEnable(feOut),
    .rxFifoFlush(rxFl), .txFifoFlush(txFl), .divLatchSel(dls),
    .baudDivisor(div), .sampleTick(smp), .bitTick(bitTick));
  uifc_fifo_model i_fifo (.clk(clk), .rst(rst), .rxFlush(rxFl),
    .txFlush(txFl), .load(load), .rxLoad(rxLd), .txLoad(txLd),
    .rxCount(rxCnt), .txCount(txCnt));

  // ******************
  // Helpers
  // ******************
  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
    return seed;
  endfunction
  function automatic logic [7:0] expId();
    logic [3:0] c;
    c = 4'h1;
    if (src.busyDetect)
      c = 4'h7;
    if (ien[3] && src.modemStatus)
      c = 4'h0;
    if (ien[1] && (ien[7] && fe ? txCnt <= thr : src.txHoldingEmpty))
      c = 4'h2;
    if (ien[0] && (fe ? rxCnt >= trg : rxCnt != 5'h00))
      c = 4'h4;
    if (ien[0] && fe && src.charTimeout)
      c = 4'hc;
    if (ien[2] && src.lineStatus)
      c = 4'h6;
    return {fe, fe, 2'b00, c};
  endfunction
  task automatic end_of_test();
    if (numErrors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] s,
                     input logic [33:0] v);
    checks++;
    if (s !== v) begin
      numErrors++;
      $display("wrong value %s exp %h seen %h", nm, v, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d},
             wstrb: 4'hf, bready: 1'b1, default: '0};
    do begin
      @(posedge clk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rc(input string nm, input logic [31:0] a, input logic [7:0] d,
                    input logic [1:0] r = uifc_pkg::RESP_OKAY);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge clk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    chk(nm, {rsp.rresp, rsp.rdata}, {r, 24'h0, d});
    req <= '0;
    @(posedge clk);
  endtask

  // ******************
  // Sequence
  // ******************
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc("ienReset", AI, 8'h00);
    rc("identReset", AF, 8'h01);
    rc("unmapped", 32'h5000_1114, 8'h00, uifc_pkg::RESP_SLVERR);
    wr(AI, 8'h0f);
    ien = 8'h0f;
    wr(AL, 8'h80);
    chk("divSel", dls, 1'b1);
    e = 8'(rnd());
    wr(AI, e);
    wr(AD, 8'h02);
    rc("divHigh", AI, e);
    chk("divisor", div, {e, 8'h02});
    wr(AI, 8'h00);
    do @(posedge clk); while (!bitTick);
    n = 0;
    m = 0;
    do begin
      @(posedge clk);
      n++;
      m += smp;
    end while (!bitTick);
    chk("bitPeriod", n, 32);
    chk("ticksPerBit", m, 16);
    wr(AL, 8'h00);
    chk("divSelOff", dls, 1'b0);
    rc("ienKept", AI, 8'h0f);
    src <= 5'h01;
    repeat (2) @(posedge clk);
    rc("busy", AF, 8'h07);
    src <= 5'h03;
    repeat (2) @(posedge clk);
    rc("modem", AF, 8'h00);
    repeat (60) begin
      x = 8'(rnd());
      wr(AF, x);
      chk("rxFlushed", rxCnt, x[1] ? 5'h00 : rxLd);
      chk("txFlushed", txCnt, x[2] ? 5'h00 : txLd);
      chk("fifoEn", feOut, x[0]);
      fe = x[0];
      xm = x[3];
      thr = TXL[x[5:4]];
      trg = RXL[x[7:6]];
      e = 8'(rnd());
      wr(AI, e);
      ien = e & 8'h8f;
      seed = rnd();
      src <= seed[4:0];
      rxLd <= 5'(seed[13:8] % 6'd17);
      txLd <= 5'(seed[21:16] % 6'd17);
      af <= seed[24];
      rtsReq <= seed[25];
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      repeat (2) @(posedge clk);
      x = expId();
      rc("ident", AF, x);
      chk("irq", irq, x[3:0] != 4'h1);
      chk("rtsN", rtsN, !(rtsReq && !(af && fe && rxCnt >= trg)));
      chk("dmaRxN", dmaRxN,
          !(fe && xm ? rxCnt >= trg || src.charTimeout : rxCnt != 0));
      chk("dmaTxN", dmaTxN,
          !(!fe ? src.txHoldingEmpty : xm ? txCnt <= thr : txCnt == 0));
    end
    end_of_test();
  end
endmodule

/* File: verif/uifc_fifo_model.sv */
`timescale 1ns/10ps
module uifc_fifo_model (
  input  wire logic       clk,     // Clock
  input  wire logic       rst,     // Async reset
  input  wire logic       rxFlush, // Receive flush pulse
  input  wire logic       txFlush, // Transmit flush pulse
  input  wire logic       load,    // Take new fill levels
  input  wire logic [4:0] rxLoad,  // New receive fill
  input  wire logic [4:0] txLoad,  // New transmit fill
  output logic      [4:0] rxCount, // Receive fill
  output logic      [4:0] txCount  // Transmit fill
);
  // ******************
  // Fill counters
  // ******************
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rxCount <= 5'h00;
    else if (rxFlush)
      rxCount <= 5'h00;
    else if (load)
      rxCount <= rxLoad;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      txCount <= 5'h00;
    else if (txFlush)
      txCount <= 5'h00;
    else if (load)
      txCount <= txLoad;
  end
endmodule
